// File: dv/sac_link_monitor.sv
// assertions on the serial link and the conversion status of the converter end
module sac_link_monitor
  import sac_pkg::*;
(
  // conversion clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link
  input wire logic cs_n,
  input wire logic addr_in,
  input wire logic io_clk,
  input wire logic data_out,
  input wire logic data_oe_n,
  // device status
  input wire logic sampling,
  input wire logic busy,
  input wire logic done,
  input wire logic [RES_W-1:0] result
);
  timeunit 1ns;
  timeprecision 1ns;
  logic io_q_r;
  logic io_fall;
  logic [CNT_W-1:0] fall_cnt_r;
  logic [6:0] busy_cnt_r;

  // io clock is sampled here; valid only while its phases span several conversion clocks
  assign io_fall = io_q_r & ~io_clk;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      io_q_r <= 1'b0;
    end else begin
      io_q_r <= io_clk;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fall_cnt_r <= 4'h0;
    end else if (data_oe_n) begin
      fall_cnt_r <= 4'h0;
    end else if (io_fall) begin
      fall_cnt_r <= (fall_cnt_r == XFER_LAST) ? 4'h0 : fall_cnt_r + 4'h1;
    end
  end

  // saturates so a stuck busy cannot wrap into the legal window
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt_r <= 7'h00;
    end else if (!busy) begin
      busy_cnt_r <= 7'h00;
    end else if (busy_cnt_r != 7'h7f) begin
      busy_cnt_r <= busy_cnt_r + 7'h01;
    end
  end

  default clocking dck @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  AST_OE_RELEASED: assert property (cs_n [*5] |-> data_oe_n)
    else $error("output driven while select high");
  AST_CS_FILTER: assert property ($fell(cs_n) |-> data_oe_n ##1 data_oe_n ##[1:4] !data_oe_n)
    else $error("select recognised too early or not at all");
  AST_MSB_FIRST: assert property ($fell(data_oe_n) |-> !io_clk && data_out == result[RES_W-1])
    else $error("msb not presented at recognition");
  AST_SHIFT_ON_FALL: assert property (!data_oe_n && $past(!data_oe_n) && $changed(data_out)
    |-> io_fall)
    else $error("result bit changed off a falling edge");
  AST_SAMPLE_LATE: assert property (io_fall && fall_cnt_r < SAMPLE_FALL |-> !sampling)
    else $error("sampling before fourth fall");
  AST_SAMPLE_OPEN: assert property (io_fall && fall_cnt_r == SAMPLE_FALL |-> ##[1:5] sampling)
    else $error("sampling did not start");
  AST_STROBE_HOLD: assert property (io_clk && fall_cnt_r == XFER_LAST |-> sampling && !busy)
    else $error("hold before tenth fall");
  AST_CONV_START: assert property (io_fall && fall_cnt_r == XFER_LAST |-> ##[1:6] busy)
    else $error("conversion did not start");
  AST_CONV_LEN: assert property (done |-> busy_cnt_r >= 7'h2a && busy_cnt_r <= 7'h2e)
    else $error("conversion length wrong");
  AST_RESULT_KEEP: assert property ($changed(result) |-> done)
    else $error("result changed without completion");
endmodule

// File: dv/serial_adc_conversion_sequencer_tb.sv
// self-checking bench: host and converter ends joined over the serial link
module serial_adc_conversion_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sac_pkg::*;
  localparam logic [RES_W-1:0] TEST_CODE = 10'h1f8;
  logic clk = 1'b0;
  logic dclk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  logic [ADDR_W-1:0] req_addr = 4'h0;
  logic strobe_hold = 1'b0;
  logic strobe_trig = 1'b0;
  logic res_ready = 1'b0;
  logic [RES_W-1:0] sample_code = 10'h000;
  logic req_ready, res_valid, sampling, busy, done;
  logic [FIFO_W-1:0] res_data;
  logic [ADDR_W-1:0] channel, ad, prev_addr;
  logic [RES_W-1:0] result, rx, prev_res;
  logic [FIFO_W-1:0] exp_q[$];
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  int bitn = 0;

  sac_link_if link_bus ();
  sac_host sac_host_inst (.clk(clk), .rst_n(rst_n), .link(link_bus), .req_valid(req_valid),
    .req_ready(req_ready), .req_addr(req_addr), .strobe_hold(strobe_hold),
    .strobe_trig(strobe_trig), .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data));
  sac_device #(.SELF_TEST_CODE(TEST_CODE)) sac_device_inst (.clk(dclk), .rst_n(rst_n),
    .link(link_bus), .sample_code(sample_code), .channel(channel), .sampling(sampling),
    .busy(busy), .done(done), .result(result));
  sac_link_monitor sac_link_monitor_inst (.clk(dclk), .rst_n(rst_n), .cs_n(link_bus.cs_n),
    .addr_in(link_bus.addr_in), .io_clk(link_bus.io_clk), .data_out(link_bus.data_out),
    .data_oe_n(link_bus.data_oe_n), .sampling(sampling), .busy(busy), .done(done),
    .result(result));

  initial begin
    forever #20 clk = ~clk;
  end
  // odd offset keeps conversion clock edges off the host grid
  initial begin
    #7;
    forever #24 dclk = ~dclk;
  end

  task automatic chk1(input logic g, input logic e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chkw(input logic [FIFO_W-1:0] g, input logic [FIFO_W-1:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask

  task automatic print_verdict;
    $display("mismatches %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end

  // wire observer: bits taken at io rises, as the host samples them
  always @(negedge link_bus.cs_n) bitn = 0;
  always @(posedge link_bus.io_clk) begin
    if (bitn < 4) ad = {ad[2:0], link_bus.addr_in};
    rx = {rx[8:0], link_bus.data_line};
    bitn++;
  end

  always @(posedge clk) begin
    if (res_valid === 1'b1 && res_ready === 1'b1) chkw(res_data, exp_q.pop_front());
  end

  task automatic frame(input logic [3:0] a, input logic [9:0] code, input logic strobe);
    int n;
    logic [RES_W-1:0] want;
    @(posedge dclk);
    sample_code <= code;
    @(posedge clk);
    req_valid <= 1'b1;
    req_addr <= a;
    strobe_hold <= strobe;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 50);
    req_valid <= 1'b0;
    strobe_hold <= 1'b0;
    chk1(req_ready, 1'b1);
    want = prev_res;
    exp_q.push_back({prev_addr, prev_res});
    prev_addr = a;
    prev_res = (a == SELF_TEST_CHANNEL) ? TEST_CODE : code;
    if (strobe) begin
      repeat (200) @(posedge clk);
      chk1(link_bus.io_clk, 1'b1);
      chk1(busy, 1'b0);
      chk1(sampling, 1'b1);
      strobe_trig <= 1'b1;
      @(posedge clk);
      strobe_trig <= 1'b0;
    end
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (link_bus.cs_n !== 1'b1 && n < 400);
    repeat (70) @(posedge clk);
    chk1(link_bus.data_line, 1'b1);
    chkw(14'(bitn), 14'h00a);
    chkw({10'h000, ad}, {10'h000, a});
    chkw({4'h0, rx}, {4'h0, want});
    chkw({10'h000, channel}, {10'h000, a});
  endtask

  task automatic t_reset;
    repeat (5) @(posedge clk);
    chk1(link_bus.cs_n, 1'b1);
    chk1(link_bus.data_line, 1'b1);
    chk1(busy, 1'b0);
    chk1(res_valid, 1'b0);
    chkw({4'h0, result}, {4'h0, RESULT_RST});
  endtask

  // fifo filled with the drain stalled, one request refused, then drained empty
  task automatic t_fill;
    int n;
    for (int i = 0; i < FIFO_DEPTH; i++) frame(4'(i * 3 + 2), 10'h3ff - 10'(i * 37), 1'b0);
    req_valid <= 1'b1;
    n = 0;
    repeat (300) begin
      @(posedge clk);
      if (req_ready === 1'b1) n++;
    end
    req_valid <= 1'b0;
    chkw(14'(n), 14'h0000);
    res_ready <= 1'b1;
    repeat (12) @(posedge clk);
    chk1(res_valid, 1'b0);
  endtask

  task automatic t_strobe;
    frame(4'hf, 10'h155, 1'b1);
    frame(4'h0, 10'h2aa, 1'b0);
  endtask

  initial begin
    prev_addr = 4'h0;
    prev_res = RESULT_RST;
    t_reset();
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_fill();
    t_strobe();
    repeat (20) @(posedge clk);
    chkw(14'(exp_q.size()), 14'h0000);
    print_verdict();
  end
endmodule

// File: hdl/sac_device.sv
// converter end: select recognition, serial shifting and conversion sequencing
module sac_device
  import sac_pkg::*;
#(
  parameter logic [RES_W-1:0] SELF_TEST_CODE = 10'h200
) (
  // conversion clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link
  sac_link_if.dev link,
  // analog stand-in, digitised value of the addressed channel
  input wire logic [RES_W-1:0] sample_code,
  // status
  output logic [ADDR_W-1:0] channel,
  output logic sampling,
  output logic busy,
  output logic done,
  output logic [RES_W-1:0] result
);

  logic cs_s1_r;
  logic cs_s2_r;
  logic cs_act_r;
  logic cs_act_d_r;
  logic oe_n_r;
  logic frame_rst_n;
  logic [CNT_W-1:0] rise_cnt_r;
  logic [CNT_W-1:0] fall_cnt_r;
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] chan_io_r;
  logic sampling_io_r;
  logic start_tgl_r;
  logic tgl_s1_r;
  logic tgl_s2_r;
  logic tgl_s3_r;
  logic smp_s1_r;
  logic smp_s2_r;
  logic start_pulse;
  logic [CONV_W-1:0] conv_cnt_r;
  logic busy_r;
  logic done_r;
  logic [ADDR_W-1:0] channel_r;
  logic [RES_W-1:0] code_r;
  logic [RES_W-1:0] result_r;

  // select synchroniser: two rising edges of the conversion clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
    end else begin
      cs_s1_r <= link.cs_n;
      cs_s2_r <= cs_s1_r;
    end
  end

  // then one falling edge before the low level counts
  always_ff @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_act_r <= 1'b0;
    end else begin
      cs_act_r <= ~cs_s2_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_act_d_r <= 1'b0;
      oe_n_r <= 1'b1;
    end else begin
      cs_act_d_r <= cs_act_r;
      oe_n_r <= ~cs_act_r;
    end
  end

  // transfer logic sits in reset whenever select is not recognised,
  // so stray transfer clocks and address bits have no effect
  assign frame_rst_n = rst_n & cs_act_r;

  always_ff @(posedge link.io_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      rise_cnt_r <= '0;
    end else if (rise_cnt_r == XFER_LAST) begin
      rise_cnt_r <= '0;
    end else begin
      rise_cnt_r <= rise_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge link.io_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      addr_r <= '0;
    end else if (rise_cnt_r < ADDR_BITS) begin
      addr_r <= {addr_r[ADDR_W-2:0], link.addr_in};
    end
  end

  // falling edges select which result bit is on the line
  always_ff @(negedge link.io_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      fall_cnt_r <= '0;
    end else if (fall_cnt_r == XFER_LAST) begin
      fall_cnt_r <= '0;
    end else begin
      fall_cnt_r <= fall_cnt_r + 4'h1;
    end
  end

  always_ff @(negedge link.io_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      sampling_io_r <= 1'b0;
    end else if (fall_cnt_r == SAMPLE_FALL) begin
      sampling_io_r <= 1'b1;
    end else if (fall_cnt_r == XFER_LAST) begin
      sampling_io_r <= 1'b0;
    end
  end

  // start event and channel survive the frame reset: the host may
  // drop select right after the tenth fall, before the crossing lands
  always_ff @(negedge link.io_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_tgl_r <= 1'b0;
      chan_io_r <= '0;
    end else if (fall_cnt_r == XFER_LAST) begin
      start_tgl_r <= ~start_tgl_r;
      chan_io_r <= addr_r;
    end
  end

  // line bit comes from the held result, msb first, no clock needed
  assign link.data_out = result_r[RES_W-1-int'(fall_cnt_r)];
  assign link.data_oe_n = oe_n_r;

  // crossings into the conversion clock domain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      tgl_s3_r <= 1'b0;
      smp_s1_r <= 1'b0;
      smp_s2_r <= 1'b0;
    end else begin
      tgl_s1_r <= start_tgl_r;
      tgl_s2_r <= tgl_s1_r;
      tgl_s3_r <= tgl_s2_r;
      smp_s1_r <= sampling_io_r;
      smp_s2_r <= smp_s1_r;
    end
  end

  assign start_pulse = tgl_s2_r ^ tgl_s3_r;

  // conversion runs on the conversion clock only, with or without select
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      conv_cnt_r <= '0;
    end else if (start_pulse) begin
      busy_r <= 1'b1;
      conv_cnt_r <= '0;
    end else if (cs_act_r && !cs_act_d_r) begin
      busy_r <= 1'b0;
      conv_cnt_r <= '0;
    end else if (busy_r) begin
      if (conv_cnt_r == CONV_CYCLES - 6'h1) begin
        busy_r <= 1'b0;
        conv_cnt_r <= '0;
      end else begin
        conv_cnt_r <= conv_cnt_r + 6'h1;
      end
    end
  end

  // hold: the code is frozen when the conversion starts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_r <= '0;
      code_r <= RESULT_RST;
    end else if (start_pulse) begin
      channel_r <= chan_io_r;
      if (chan_io_r == SELF_TEST_CHANNEL) begin
        code_r <= SELF_TEST_CODE;
      end else begin
        code_r <= sample_code;
      end
    end
  end

  // an aborted conversion never reaches the result register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_r <= RESULT_RST;
      done_r <= 1'b0;
    end else if (busy_r && !start_pulse && !(cs_act_r && !cs_act_d_r)
                 && conv_cnt_r == CONV_CYCLES - 6'h1) begin
      result_r <= code_r;
      done_r <= 1'b1;
    end else begin
      done_r <= 1'b0;
    end
  end

  assign channel = channel_r;
  assign sampling = smp_s2_r;
  assign busy = busy_r;
  assign done = done_r;
  assign result = result_r;

endmodule

// File: hdl/sac_host.sv
// controller end: frame sequencer, transfer clock divider and result fifo
module sac_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW:0] wp_r;
  logic [PW:0] rp_r;
  logic full;
  logic empty;

  assign empty = (wp_r == rp_r);
  assign full = (wp_r[PW] != rp_r[PW]) && (wp_r[PW-1:0] == rp_r[PW-1:0]);
  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign out_data = mem_r[rp_r[PW-1:0]];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
    end else if (in_valid && !full) begin
      wp_r <= wp_r + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (in_valid && !full) begin
      mem_r[wp_r[PW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rp_r <= '0;
    end else if (out_ready && !empty) begin
      rp_r <= rp_r + 1'b1;
    end
  end
endmodule

module sac_host
  import sac_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link
  sac_link_if.host link,
  // conversion request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [ADDR_W-1:0] req_addr,
  // strobed start: hold the tenth clock high until trigger
  input wire logic strobe_hold,
  input wire logic strobe_trig,
  // results: channel of the earlier request and its code
  output logic res_valid,
  input wire logic res_ready,
  output logic [FIFO_W-1:0] res_data
);
  sac_host_e state_r;
  logic cs_n_r;
  logic io_clk_r;
  logic addr_bit_r;
  logic req_ready_r;
  logic [HALF_W-1:0] ph_r;
  logic [CNT_W-1:0] bit_r;
  logic [WAIT_W-1:0] wait_r;
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] prev_addr_r;
  logic [RES_W-1:0] shift_r;
  logic hold_r;
  logic d_s1_r;
  logic d_s2_r;
  logic push;
  logic fifo_ready;

  assign link.cs_n = cs_n_r;
  assign link.io_clk = io_clk_r;
  assign link.addr_in = addr_bit_r;
  assign req_ready = req_ready_r;
  assign push = (state_r == SAC_PUSH);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      d_s1_r <= 1'b1;
      d_s2_r <= 1'b1;
    end else begin
      d_s1_r <= link.data_line;
      d_s2_r <= d_s1_r;
    end
  end

  // a new frame waits for fifo room, so a stalled reader stalls the link
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= SAC_IDLE;
      cs_n_r <= 1'b1;
      io_clk_r <= 1'b0;
      addr_bit_r <= 1'b0;
      req_ready_r <= 1'b0;
      ph_r <= '0;
      bit_r <= '0;
      wait_r <= '0;
      addr_r <= '0;
      prev_addr_r <= '0;
      shift_r <= '0;
      hold_r <= 1'b0;
    end else begin
      req_ready_r <= 1'b0;
      case (state_r)
        SAC_IDLE: begin
          if (req_valid && fifo_ready && !req_ready_r) begin
            req_ready_r <= 1'b1;
            addr_r <= req_addr;
            hold_r <= strobe_hold;
            cs_n_r <= 1'b0;
            wait_r <= '0;
            state_r <= SAC_SELECT;
          end
        end
        SAC_SELECT: begin
          wait_r <= wait_r + 7'h01;
          if (wait_r == CS_SETUP_CYC) begin
            bit_r <= '0;
            ph_r <= '0;
            state_r <= SAC_LOW;
          end
        end
        SAC_LOW: begin
          if (ph_r == '0) begin
            addr_bit_r <= addr_r[ADDR_W-1];
          end
          ph_r <= ph_r + 3'h1;
          if (ph_r == IO_HALF - 3'h1) begin
            io_clk_r <= 1'b1;
            shift_r <= {shift_r[RES_W-2:0], d_s2_r};
            ph_r <= '0;
            state_r <= SAC_HIGH;
          end
        end
        SAC_HIGH: begin
          if (ph_r != IO_HALF - 3'h1) begin
            ph_r <= ph_r + 3'h1;
          end else if (bit_r == XFER_LAST && hold_r && !strobe_trig) begin
            ph_r <= ph_r;
          end else begin
            io_clk_r <= 1'b0;
            addr_r <= {addr_r[ADDR_W-2:0], 1'b0};
            ph_r <= '0;
            bit_r <= bit_r + 4'h1;
            if (bit_r == XFER_LAST) begin
              wait_r <= '0;
              state_r <= SAC_CONVERT;
            end else begin
              state_r <= SAC_LOW;
            end
          end
        end
        SAC_CONVERT: begin
          cs_n_r <= 1'b1;
          wait_r <= wait_r + 7'h01;
          if (wait_r == CONV_WAIT_CYC) begin
            state_r <= SAC_PUSH;
          end
        end
        SAC_PUSH: begin
          prev_addr_r <= req_addr_latched();
          state_r <= SAC_IDLE;
        end
        default: begin
          state_r <= SAC_IDLE;
        end
      endcase
    end
  end

  // address of this frame, kept to tag the result read in the next one
  logic [ADDR_W-1:0] cur_addr_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_addr_r <= '0;
    end else if (state_r == SAC_IDLE && req_valid && fifo_ready && !req_ready_r) begin
      cur_addr_r <= req_addr;
    end
  end

  function automatic logic [ADDR_W-1:0] req_addr_latched();
    return cur_addr_r;
  endfunction

  sac_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data({prev_addr_r, shift_r}),
    .out_valid(res_valid),
    .out_ready(res_ready),
    .out_data(res_data)
  );
endmodule

// File: hdl/sac_link_if.sv
// serial link wires between controller and converter
interface sac_link_if;
  logic cs_n;
  logic addr_in;
  logic io_clk;
  logic data_out;
  logic data_oe_n;
  logic data_line;

  // released line reads high, as with a pull-up
  assign data_line = data_oe_n ? 1'b1 : data_out;

  modport dev (
    input cs_n,
    input addr_in,
    input io_clk,
    output data_out,
    output data_oe_n
  );

  modport host (
    output cs_n,
    output addr_in,
    output io_clk,
    input data_line
  );
endinterface

// File: hdl/sac_pkg.sv
// constants and types shared by both ends of the serial converter link
// Operation
// - chip select high: output released, inputs ignored
// - low chip select needs two rises, one fall
// - msb appears at once after recognition
// - four address bits on first rises, msb first
// - first four falls shift result bits two-five
// - sampling starts after fourth falling edge
// - falls five to nine shift bits six-ten
// - tenth fall holds and starts 44-cycle conversion
// - host raises select or idles clock 44 cycles
// - select may stay low; clock must be clean
// - select high until done; recognised fall aborts
// - new full access aborts, restarts, keeps old result
// - conversion and transfer clocks fully independent
// - shared clock: first two clocks only recognise
// - shared clock converts while select is high
// - shared clock: raise select after twelfth clock
// - strobed start: clock held high delays hold
// - address 1011 converts internal self-test input
package sac_pkg;
  localparam int RES_W = 10;
  localparam int ADDR_W = 4;
  localparam int CNT_W = 4;
  localparam int CONV_W = 6;
  localparam logic [CNT_W-1:0] ADDR_BITS = 4'h4;
  localparam logic [CNT_W-1:0] XFER_LAST = 4'h9;
  localparam logic [CNT_W-1:0] SAMPLE_FALL = 4'h3;
  localparam logic [CONV_W-1:0] CONV_CYCLES = 6'h2c;
  localparam logic [ADDR_W-1:0] SELF_TEST_CHANNEL = 4'hb;
  localparam logic [RES_W-1:0] RESULT_RST = 10'h000;
  // host timing, in host clock cycles
  localparam int HALF_W = 3;
  localparam logic [HALF_W-1:0] IO_HALF = 3'h4;
  localparam int WAIT_W = 7;
  localparam logic [WAIT_W-1:0] CS_SETUP_CYC = 7'h08;
  localparam logic [WAIT_W-1:0] CONV_WAIT_CYC = 7'h40;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W = ADDR_W + RES_W;
  typedef enum logic [2:0] {
    SAC_IDLE,
    SAC_SELECT,
    SAC_LOW,
    SAC_HIGH,
    SAC_CONVERT,
    SAC_PUSH
  } sac_host_e;
endpackage
